// ### shared/micro_io_pkg.sv
// shared constants and carriers for the micro io and counter mode block
// ==========================================================
// How it works
// - io starts only on load naming io port
// - acknowledge copies interrupting device, clears attention flag
// - data request reads selected non-panel device
// - status request senses device, panel gives status
// - address loads selected device; panel clears execute, count
// - data available writes device or panel indicator byte
// - command outputs to device, panel ignores it
// - shutdown bit in command halts execution
// - counter command sets mode, clears phase count
// - nonzero mode runs post execution handling
// - hold rom address low in counting phases
// - source work register becomes paired next
// - destination work register becomes paired next
// - divide phase three cancels store without carry
// - rom address low wraps within page
// - io as both source and destination rejected
package micro_io_pkg;
  localparam logic [1:0] E_NONE = 2'h0;
  localparam logic [1:0] E_ACK = 2'h1;
  localparam logic [1:0] E_DATA = 2'h2;
  localparam logic [1:0] E_STAT = 2'h3;
  localparam logic [7:0] PANEL_DEV = 8'h01;
  localparam logic [1:0] COUNT_WRAP = 2'h3;
  localparam int ATTN_BIT = 5;
  localparam int CONSOLE_BIT = 7;
  localparam int SHUTDOWN_BIT = 15;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PRODUCT = 2'h1;
  localparam logic [1:0] MODE_DIVIDE = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;
  localparam logic [31:0] ADDR_CTRL = 32'h00;
  localparam logic [31:0] ADDR_STATUS = 32'h04;
  localparam logic [31:0] ADDR_SWITCH = 32'h08;
  localparam logic [31:0] ADDR_IND = 32'h0c;
  localparam logic [31:0] ADDR_DEVS = 32'h10;
  localparam logic [31:0] ADDR_IRQ = 32'h14;
  localparam logic [31:0] ADDR_MASK = 32'h18;
  localparam logic [31:0] ADDR_MODE = 32'h1c;
  localparam int IRQ_W = 4;
  localparam int IRQ_IOERR = 0;
  localparam int IRQ_HALT = 1;
  localparam int IRQ_DEVREQ = 2;
  localparam int IRQ_POST = 3;
  typedef struct packed {
    logic valid;
    logic is_load;
    logic src_io;
    logic dst_io;
    logic is_cmd;
    logic [1:0] cmd_mode;
    logic [3:0] e_field;
    logic [15:0] src_data;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
  } uop_s;
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [7:0] dev;
    logic [15:0] data;
  } dev_req_s;
endpackage : micro_io_pkg

// ### hdl/micro_io_ctrl.sv
// micro io decode, panel cells and counter mode control with apb registers
//
// Added by the designer: the address map and register access over APB.
module micro_io_ctrl
  import micro_io_pkg::*;
#(
  parameter int REG_W = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire uop_s uop_i,
  input wire logic fetch_i,
  input wire logic [15:0] dev_data_i,
  input wire logic dev_ack_i,
  input wire logic carry_i,
  input wire logic attn_pin_i,
  output dev_req_s dev_req_o,
  output logic dst_we_o,
  output logic [REG_W-1:0] dst_reg_o,
  output logic [REG_W-1:0] src_reg_o,
  output logic [15:0] dst_data_o,
  output logic [7:0] rom_addr_low_o,
  output logic halted_o,
  output logic post_exec_o,
  output logic irq_o
);
  if (REG_W != 4) begin : g_reg_w_check
    $error("register field must be 4 bits");
  end

  // ==========================================================
  // state
  logic [7:0] panel_switch_high_q, panel_switch_low_q, panel_status_q;
  logic [1:0] byte_count_q;
  logic [7:0] indicator_q [4];
  logic [7:0] selected_device_cell_q, interrupting_device_cell_q;
  logic attention_flag_q, console_execute_flag_q;
  logic [1:0] mode_q;
  logic [1:0] phase_q;
  logic [REG_W-1:0] work_pair_reg_q;
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic attn_s1_q, attn_s2_q;
  logic pend_q;
  logic [3:0] pend_dst_q;

  // ==========================================================
  // decode
  logic io_op, io_both, ack_src, data_src, stat_src, addr_dst, data_dst, cmd_dst, io_err;
  logic panel_sel, shutdown, cnt_cmd;
  logic [1:0] ef;
  logic [IRQ_W-1:0] ev;
  assign ef = uop_i.e_field[1:0];
  assign io_both = uop_i.valid && uop_i.is_load && uop_i.src_io && uop_i.dst_io;
  assign io_op = uop_i.valid && uop_i.is_load && (uop_i.src_io ^ uop_i.dst_io) && !halted_o
    && !pend_q;
  assign io_err = (io_op && ef == E_NONE) || io_both;
  assign ack_src = io_op && uop_i.src_io && ef == E_ACK;
  assign data_src = io_op && uop_i.src_io && ef == E_DATA;
  assign stat_src = io_op && uop_i.src_io && ef == E_STAT;
  assign addr_dst = io_op && uop_i.dst_io && ef == E_ACK;
  assign data_dst = io_op && uop_i.dst_io && ef == E_DATA;
  assign cmd_dst = io_op && uop_i.dst_io && ef == E_STAT;
  // no device range check: microcode keeps to real devices
  assign panel_sel = selected_device_cell_q == PANEL_DEV;
  assign shutdown = uop_i.valid && uop_i.is_cmd && uop_i.src_data[SHUTDOWN_BIT] && !halted_o;
  assign cnt_cmd = uop_i.valid && uop_i.is_cmd && uop_i.cmd_mode != MODE_OFF && !halted_o;
  logic sub_pair;
  assign sub_pair = (mode_q == MODE_PRODUCT && phase_q == 2'h2)
    || (mode_q == MODE_DIVIDE && phase_q == 2'h1);
  // stores of the current op are cut, panel and ack io loads included; device read returns are not
  logic store_cut;
  assign store_cut = mode_q == MODE_DIVIDE && phase_q == 2'h3 && !carry_i;
  logic dev_start;
  assign dev_start = ((data_src || stat_src) && !panel_sel)
    || ((data_dst || cmd_dst) && !panel_sel);
  assign ev = {post_exec_o, dev_start, shutdown, io_err};

  // ==========================================================
  // synchroniser for the external attention line
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      attn_s1_q <= 1'b0;
      attn_s2_q <= 1'b0;
    end else begin
      attn_s1_q <= attn_pin_i;
      attn_s2_q <= attn_s1_q;
    end
  end

  // ==========================================================
  // apb
  logic apb_wr, apb_rd;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && !penable_i && !pwrite_i;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      // no wait state; read data is registered in the setup cycle
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && paddr_i > ADDR_MODE;
      if (apb_rd) begin
        unique case (paddr_i)
          ADDR_CTRL: prdata_o <= {31'h0, halted_o};
          ADDR_STATUS: prdata_o <= {24'h0, console_execute_flag_q, 1'b0, attention_flag_q,
            5'h0};
          ADDR_SWITCH: prdata_o <= {16'h0, panel_switch_high_q, panel_switch_low_q};
          ADDR_IND: prdata_o <= {indicator_q[3], indicator_q[2], indicator_q[1],
            indicator_q[0]};
          ADDR_DEVS: prdata_o <= {14'h0, byte_count_q, selected_device_cell_q,
            interrupting_device_cell_q};
          ADDR_IRQ: prdata_o <= {28'h0, irq_stat_q};
          ADDR_MASK: prdata_o <= {28'h0, irq_mask_q};
          ADDR_MODE: prdata_o <= {24'h0, panel_status_q};
          default: prdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // panel cells and device cells
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      panel_switch_high_q <= 8'h0;
      panel_switch_low_q <= 8'h0;
      panel_status_q <= 8'h0;
      interrupting_device_cell_q <= 8'h0;
      selected_device_cell_q <= 8'h0;
      byte_count_q <= 2'h0;
      for (int i = 0; i < 4; i++) indicator_q[i] <= 8'h0;
    end else begin
      if (apb_wr && pready_o && paddr_i == ADDR_SWITCH) begin
        panel_switch_high_q <= pwdata_i[15:8];
        panel_switch_low_q <= pwdata_i[7:0];
      end
      if (apb_wr && pready_o && paddr_i == ADDR_MODE) panel_status_q <= pwdata_i[7:0];
      if (apb_wr && pready_o && paddr_i == ADDR_DEVS)
        interrupting_device_cell_q <= pwdata_i[7:0];
      if (addr_dst) begin
        selected_device_cell_q <= uop_i.src_data[7:0];
        if (uop_i.src_data[7:0] == PANEL_DEV) byte_count_q <= 2'h0;
      end else if ((data_src || data_dst) && panel_sel) begin
        byte_count_q <= (byte_count_q == COUNT_WRAP) ? 2'h0 : byte_count_q + 2'h1;
      end
      if (data_dst && panel_sel) indicator_q[byte_count_q] <= uop_i.src_data[7:0];
    end
  end

  // ==========================================================
  // status flags; a hardware set beats a clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      attention_flag_q <= 1'b0;
      console_execute_flag_q <= 1'b0;
    end else begin
      if (attn_s2_q) attention_flag_q <= 1'b1;
      else if (ack_src) attention_flag_q <= 1'b0;
      if (apb_wr && pready_o && paddr_i == ADDR_STATUS && pwdata_i[CONSOLE_BIT])
        console_execute_flag_q <= 1'b1;
      else if (addr_dst && uop_i.src_data[7:0] == PANEL_DEV)
        console_execute_flag_q <= 1'b0;
    end
  end

  // ==========================================================
  // destination write path and external device requests
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dst_we_o <= 1'b0;
      dst_reg_o <= '0;
      dst_data_o <= 16'h0;
      dev_req_o <= '0;
      pend_q <= 1'b0;
      pend_dst_q <= 4'h0;
    end else begin
      dst_we_o <= 1'b0;
      dev_req_o.valid <= 1'b0;
      dst_reg_o <= (uop_i.dst_reg == work_pair_reg_q && sub_pair) ? work_pair_reg_q + 4'h1
        : uop_i.dst_reg;
      if (ack_src) begin
        dst_we_o <= !store_cut;
        dst_data_o <= {8'h0, interrupting_device_cell_q};
      end else if (data_src && panel_sel) begin
        dst_we_o <= !store_cut;
        dst_data_o <= {8'h0, byte_count_q[0] ? panel_switch_high_q : panel_switch_low_q};
      end else if (stat_src && panel_sel) begin
        dst_we_o <= !store_cut;
        dst_data_o <= {8'h0, panel_status_q};
      end else if (pend_q && dev_ack_i) begin
        pend_q <= 1'b0;
        dst_we_o <= 1'b1;
        dst_reg_o <= pend_dst_q;
        dst_data_o <= dev_data_i;
      end else if (uop_i.valid && !io_op && !io_both && !uop_i.is_cmd && !halted_o) begin
        dst_we_o <= !store_cut;
        dst_data_o <= uop_i.src_data;
      end
      if (dev_start) begin
        dev_req_o.valid <= 1'b1;
        dev_req_o.kind <= uop_i.src_io ? ef : ef ^ 2'h1;
        dev_req_o.dev <= selected_device_cell_q;
        dev_req_o.data <= uop_i.src_data;
        pend_q <= uop_i.src_io;
        pend_dst_q <= uop_i.dst_reg;
      end
    end
  end

  // source select with paired next substitution
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      src_reg_o <= '0;
    end else begin
      src_reg_o <= (uop_i.src_reg == work_pair_reg_q && sub_pair) ? work_pair_reg_q + 4'h1
        : uop_i.src_reg;
    end
  end

  // ==========================================================
  // counter modes, rom address and halt
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_q <= MODE_OFF;
      phase_q <= 2'h0;
      work_pair_reg_q <= 4'h0;
      rom_addr_low_o <= 8'h0;
      halted_o <= 1'b0;
      post_exec_o <= 1'b0;
    end else begin
      post_exec_o <= uop_i.valid && !halted_o && mode_q != MODE_OFF;
      if (apb_wr && pready_o && paddr_i == ADDR_CTRL) begin
        halted_o <= pwdata_i[0];
        work_pair_reg_q <= pwdata_i[7:4];
        if (pwdata_i[1]) mode_q <= MODE_OFF;
      end else if (shutdown) begin
        halted_o <= 1'b1;
      end
      if (cnt_cmd) begin
        mode_q <= uop_i.cmd_mode;
        phase_q <= 2'h0;
      end else if (uop_i.valid && !halted_o && mode_q != MODE_OFF) begin
        phase_q <= phase_q + 2'h1;
      end
      // low byte only: no carry into the page
      if (fetch_i && !halted_o && !(((mode_q == MODE_PRODUCT || mode_q == MODE_DIVIDE)
          && phase_q[0]) || (mode_q == MODE_REPEAT && phase_q == 2'h1)))
        rom_addr_low_o <= rom_addr_low_o + 8'h1;
    end
  end

  // ==========================================================
  // interrupts: sticky status, write one to clear, set wins
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_o <= 1'b0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (ev[i]) irq_stat_q[i] <= 1'b1;
        else if (apb_wr && pready_o && paddr_i == ADDR_IRQ && pwdata_i[i])
          irq_stat_q[i] <= 1'b0;
      end
      if (apb_wr && pready_o && paddr_i == ADDR_MASK) irq_mask_q <= pwdata_i[IRQ_W-1:0];
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================
  // assertions
  a_ack_clears_attn: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ack_src && !attn_s2_q |=> !attention_flag_q) else $error("attention not cleared");
  a_halt_sticks: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    shutdown && !(apb_wr && pready_o) |=> halted_o [*2]) else $error("no halt");
  a_mode_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cnt_cmd |=> mode_q == $past(uop_i.cmd_mode) && phase_q == 2'h0)
    else $error("mode not loaded");
  a_div_store_cut: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    mode_q == MODE_DIVIDE && phase_q == 2'h3 && !carry_i && !dev_start && !pend_q
    |=> !dst_we_o) else $error("store not cut");
  a_rom_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fetch_i && mode_q == MODE_REPEAT && phase_q == 2'h1 && !(apb_wr && pready_o)
    |=> $stable(rom_addr_low_o)) else $error("address moved");
  a_io_error: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    io_both |=> irq_stat_q[IRQ_IOERR] && !dev_req_o.valid) else $error("io both ran");
  a_panel_silent: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_dst && panel_sel |=> !dev_req_o.valid) else $error("panel command sent");
  a_count_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    data_dst && panel_sel && byte_count_q == COUNT_WRAP |=> byte_count_q == 2'h0)
    else $error("count no wrap");
  c_panel_read: cover property (@(posedge core_clk_i) data_src && panel_sel);
  c_dev_read: cover property (@(posedge core_clk_i) dev_start ##[1:20] pend_q && dev_ack_i);
  c_divide: cover property (@(posedge core_clk_i) mode_q == MODE_DIVIDE && phase_q == 2'h3);
endmodule : micro_io_ctrl

// ### verification/dev_model.sv
// behavioural model of the external devices behind the io port
module dev_model
  import micro_io_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic slow_i,
  input wire dev_req_s req_i,
  output logic [15:0] data_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // answer logic
  int wait_q = -1;
  logic [7:0] dev_q = 8'h00;
  initial begin
    data_o = 16'h0000;
    ack_o = 1'b0;
  end
  always @(posedge core_clk_i) begin
    ack_o <= 1'b0;
    // a released bus keeps toggling so a stale value never looks valid
    data_o <= ~data_o;
    if (req_i.valid === 1'b1) begin
      dev_q <= req_i.dev;
      wait_q <= slow_i ? 6 : 0;
    end else if (wait_q == 0) begin
      ack_o <= 1'b1;
      data_o <= 16'hc3a0 ^ {8'h00, dev_q};
      wait_q <= -1;
    end else if (wait_q > 0) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule : dev_model

// ### verification/tb.sv
// self-checking bench for the micro io and counter mode block
module tb
  import micro_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  uop_s uop_i = '0;
  logic fetch_i = 1'b0;
  logic attn_pin_i = 1'b0;
  logic slow = 1'b0;
  logic carry = 1'b1;
  logic [3:0] dst_reg_o, src_reg_o;
  logic pready_o, pslverr_o, dev_ack_i, dst_we_o, halted_o, post_exec_o, irq_o;
  logic [31:0] prdata_o;
  logic [15:0] dev_data_i, dst_data_o;
  logic [7:0] rom_addr_low_o;
  dev_req_s dev_req_o, req_q;
  logic [31:0] rdata;
  logic rerr, wseen;
  logic [15:0] wdat;
  int checked = 0, failures = 0, cycles = 0, req_n = 0, post_n = 0;
  always #20 core_clk_i = ~core_clk_i;
  // ==========================================================
  // design and far side
  micro_io_ctrl i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .uop_i(uop_i),
    .fetch_i(fetch_i), .dev_data_i(dev_data_i), .dev_ack_i(dev_ack_i), .carry_i(carry),
    .attn_pin_i(attn_pin_i), .dev_req_o(dev_req_o), .dst_we_o(dst_we_o),
    .dst_reg_o(dst_reg_o), .src_reg_o(src_reg_o), .dst_data_o(dst_data_o),
    .rom_addr_low_o(rom_addr_low_o),
    .halted_o(halted_o), .post_exec_o(post_exec_o), .irq_o(irq_o));
  dev_model i_dev (.core_clk_i(core_clk_i), .slow_i(slow), .req_i(dev_req_o),
    .data_o(dev_data_i), .ack_o(dev_ack_i));
  always @(posedge core_clk_i) begin
    cycles++;
    if (dev_req_o.valid === 1'b1) begin
      req_q = dev_req_o;
      req_n++;
    end
    if (post_exec_o === 1'b1) begin
      post_n++;
    end
    if (cycles == 20000) begin
      failures++;
      complete_run;
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // pready_o ends this wait, or else the bench timeout
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  function automatic uop_s mk(logic s, logic d, logic c, logic [1:0] m, logic [3:0] e,
                              logic [15:0] v);
    mk = '{1'b1, ~c, s, d, c, m, e, v, 4'h1, 4'h2};
  endfunction : mk
  task automatic uop(input uop_s u);
    @(posedge core_clk_i);
    uop_i <= u;
    @(posedge core_clk_i);
    uop_i <= '0;
  endtask : uop
  // waits the full span so an absent store is seen as well
  task automatic we_wait;
    wseen = 1'b0;
    wdat = 16'h0;
    for (int i = 0; i < 30; i++) begin
      @(posedge core_clk_i);
      if (dst_we_o === 1'b1 && wseen == 1'b0) begin
        wseen = 1'b1;
        wdat = dst_data_o;
      end
    end
  endtask : we_wait
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk("rom_addr", 32'h0, rom_addr_low_o);
    apb(1'b0, 32'h20, 32'h0);
    chk("unmapped_err", 32'h1, rerr);
    chk("unmapped_data", 32'h0, rdata);
    $display("test reset done");
  endtask : t_reset
  task automatic t_err;
    apb(1'b1, ADDR_MASK, 32'h0);
    uop(mk(1'b1, 1'b0, 1'b0, MODE_OFF, 4'hc, 16'h0));
    we_wait;
    chk("err_store", 32'h0, wseen);
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk("ioerr_bit", 32'h1, rdata[IRQ_IOERR]);
    chk("irq_masked", 32'h0, irq_o);
    apb(1'b1, ADDR_MASK, 32'hf);
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk("irq_unmasked", 32'h1, irq_o);
    apb(1'b1, ADDR_IRQ, 32'h1);
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk("ioerr_clear", 32'h0, rdata[IRQ_IOERR]);
    chk("irq_low", 32'h0, irq_o);
    uop(mk(1'b1, 1'b1, 1'b0, MODE_OFF, 4'h1, 16'h1));
    we_wait;
    chk("both_store", 32'h0, wseen);
    apb(1'b0, ADDR_IRQ, 32'h0);
    chk("both_err", 32'h1, rdata[IRQ_IOERR]);
    apb(1'b1, ADDR_IRQ, 32'h1);
    $display("test error done");
  endtask : t_err
  task automatic t_panel;
    int n;
    apb(1'b1, ADDR_SWITCH, 32'ha55a);
    apb(1'b1, ADDR_STATUS, 32'h80);
    uop(mk(1'b0, 1'b1, 1'b0, MODE_OFF, 4'h5, 16'h0001));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("console", 32'h0, rdata[CONSOLE_BIT]);
    apb(1'b0, ADDR_DEVS, 32'h0);
    chk("select", 32'h100, rdata);
    uop(mk(1'b1, 1'b0, 1'b0, MODE_OFF, 4'he, 16'h0));
    we_wait;
    chk("sw_low", 32'h5a, wdat[7:0]);
    uop(mk(1'b1, 1'b0, 1'b0, MODE_OFF, 4'h2, 16'h0));
    we_wait;
    chk("sw_high", 32'ha5, wdat[7:0]);
    uop(mk(1'b0, 1'b1, 1'b0, MODE_OFF, 4'ha, 16'h0033));
    uop(mk(1'b0, 1'b1, 1'b0, MODE_OFF, 4'h2, 16'h0044));
    apb(1'b0, ADDR_IND, 32'h0);
    chk("ind", 32'h44330000, rdata);
    apb(1'b0, ADDR_DEVS, 32'h0);
    chk("count_wrap", 32'h100, rdata);
    n = req_n;
    uop(mk(1'b0, 1'b1, 1'b0, MODE_OFF, 4'h3, 16'h1234));
    we_wait;
    chk("panel_cmd", n, req_n);
    $display("test panel done");
  endtask : t_panel
  task automatic t_ack;
    apb(1'b1, ADDR_DEVS, 32'h07);
    @(posedge core_clk_i);
    attn_pin_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    attn_pin_i <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("attn_set", 32'h1, rdata[ATTN_BIT]);
    uop(mk(1'b1, 1'b0, 1'b0, MODE_OFF, 4'h1, 16'h0));
    we_wait;
    chk("ack_dev", 32'h07, wdat[7:0]);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("attn_clr", 32'h0, rdata[ATTN_BIT]);
    $display("test ack done");
  endtask : t_ack
  task automatic t_dev;
    int n;
    uop(mk(1'b0, 1'b1, 1'b0, MODE_OFF, 4'h1, 16'h0002));
    for (int e = 2; e < 4; e++) begin
      slow <= (e == 3);
      n = req_n;
      uop(mk(1'b1, 1'b0, 1'b0, MODE_OFF, 4'(e), 16'h0));
      we_wait;
      chk("req_n", n + 1, req_n);
      chk("req_kind", e, req_q.kind);
      chk("req_dev", 32'h2, req_q.dev);
      chk("dev_data", 32'hc3a2, wdat);
    end
    $display("test device done");
  endtask : t_dev
  task automatic t_mode;
    logic [7:0] a;
    int p;
    @(posedge core_clk_i);
    a = rom_addr_low_o;
    for (int i = 1; i <= 256; i++) begin
      fetch_i <= 1'b1;
      @(posedge core_clk_i);
      fetch_i <= 1'b0;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      if (i == 3 || i == 256) begin
        chk("rom_addr", 8'(a + i), rom_addr_low_o);
      end
    end
    p = post_n;
    uop(mk(1'b0, 1'b0, 1'b0, MODE_OFF, 4'h0, 16'h0));
    repeat (5) @(posedge core_clk_i);
    chk("post_off", p, post_n);
    uop(mk(1'b0, 1'b0, 1'b1, MODE_PRODUCT, 4'h0, 16'h0));
    p = post_n;
    uop(mk(1'b0, 1'b0, 1'b0, MODE_OFF, 4'h0, 16'h0));
    repeat (5) @(posedge core_clk_i);
    chk("post_on", 32'h1, post_n != p);
    apb(1'b1, ADDR_CTRL, 32'h2);
    $display("test mode done");
  endtask : t_mode
  task automatic t_cnt;
    logic [7:0] a;
    uop_s u;
    u = mk(1'b0, 1'b0, 1'b0, MODE_OFF, 4'h0, 16'h0055);
    u.dst_reg = 4'h1;
    uop(mk(1'b0, 1'b0, 1'b1, MODE_REPEAT, 4'h0, 16'h0));
    uop(u);
    a = rom_addr_low_o;
    @(posedge core_clk_i);
    fetch_i <= 1'b1;
    @(posedge core_clk_i);
    fetch_i <= 1'b0;
    @(posedge core_clk_i);
    chk("rpt_hold", a, rom_addr_low_o);
    // work pair register 1, counter mode cleared
    apb(1'b1, ADDR_CTRL, 32'h12);
    uop(mk(1'b0, 1'b0, 1'b1, MODE_DIVIDE, 4'h0, 16'h0));
    uop(u);
    uop(u);
    @(posedge core_clk_i);
    chk("src_pair", 32'h2, src_reg_o);
    chk("dst_pair", 32'h2, dst_reg_o);
    uop(u);
    carry <= 1'b0;
    uop(u);
    we_wait;
    chk("div_cut", 32'h0, wseen);
    carry <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h2);
    $display("test counter done");
  endtask : t_cnt
  task automatic t_halt;
    uop(mk(1'b0, 1'b0, 1'b1, MODE_OFF, 4'h0, 16'h8000));
    repeat (3) @(posedge core_clk_i);
    chk("halted", 32'h1, halted_o);
    $display("test halt done");
  endtask : t_halt
  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_err;
    t_panel;
    t_ack;
    t_dev;
    t_mode;
    t_cnt;
    t_halt;
    complete_run;
  end
endmodule : tb
